// *** include/cwt_defines.vh ***
// register map, field positions and timing constants for the clock out and wakeup timer
`ifndef CWT_DEFINES_VH
`define CWT_DEFINES_VH
// ========================================
// register byte offsets
`define CWT_OFS_CLK_OUT_CTRL 8'h00
`define CWT_OFS_PART_HIGH 8'h04
`define CWT_OFS_PART_LOW 8'h08
`define CWT_OFS_WAKE_STAT_CTRL 8'h0C
`define CWT_OFS_IRQ_STATUS 8'h10
`define CWT_OFS_IRQ_MASK 8'h14
// ========================================
// clock_output_control fields
`define CWT_CO_PIN_EN_BIT 4
`define CWT_CO_DIV_MSB 2
`define CWT_CO_DIV_LSB 0
// ========================================
// wakeup_timer_status_control fields
`define CWT_WK_FLAG_BIT 7
`define CWT_WK_ACK_BIT 6
`define CWT_WK_CLKSEL_BIT 5
`define CWT_WK_IE_BIT 4
`define CWT_WK_DLY_MSB 2
`define CWT_WK_DLY_LSB 0
// ========================================
// interrupt status bits
`define CWT_IRQ_WAKE_BIT 0
`define CWT_IRQ_BITS 1
// ========================================
// reset values and responses
`define CWT_RST_BYTE 8'h00
`define CWT_RST_WORD 32'h0000_0000
`define CWT_RESP_OKAY 2'h0
`define CWT_RESP_SLVERR 2'h2
// ========================================
// internal oscillator rate and delays in ms
`define CWT_INT_OSC_KHZ 16'h0001
`define CWT_DLY1_MS 16'h0008
`define CWT_DLY2_MS 16'h0020
`define CWT_DLY3_MS 16'h0040
`define CWT_DLY4_MS 16'h0080
`define CWT_DLY5_MS 16'h0100
`define CWT_DLY6_MS 16'h0200
`define CWT_DLY7_MS 16'h0400
// ========================================
// external clock divide ratios
`define CWT_XDIV1 16'h0100
`define CWT_XDIV2 16'h0400
`define CWT_XDIV3 16'h0800
`define CWT_XDIV4 16'h1000
`define CWT_XDIV5 16'h2000
`define CWT_XDIV6 16'h4000
`define CWT_XDIV7 16'h8000
`endif

// *** src/cwt_top.v ***
// clock output divider, part number and periodic wakeup timer with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`include "cwt_defines.vh"

module cwt_top #(
   parameter [11:0] PART_ID = 12'h5A3, // arbitrary value
   parameter DIV_W = 3,
   parameter CNT_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire int_osc_clk,
   input wire ext_xtal_clk,
   output reg port_c_bit_two_pin_o,
   output reg port_c_bit_two_pin_oe,
   output reg wakeup_irq,
   output reg irq
);

   // ========================================
   // functions
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `CWT_OFS_CLK_OUT_CTRL) || (a == `CWT_OFS_PART_HIGH) ||
                  (a == `CWT_OFS_PART_LOW) || (a == `CWT_OFS_WAKE_STAT_CTRL) ||
                  (a == `CWT_OFS_IRQ_STATUS) || (a == `CWT_OFS_IRQ_MASK);
      end
   endfunction

   // internal source: delay select to tick count
   function [CNT_W-1:0] int_ticks;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: int_ticks = `CWT_DLY1_MS * `CWT_INT_OSC_KHZ;
            3'h2: int_ticks = `CWT_DLY2_MS * `CWT_INT_OSC_KHZ;
            3'h3: int_ticks = `CWT_DLY3_MS * `CWT_INT_OSC_KHZ;
            3'h4: int_ticks = `CWT_DLY4_MS * `CWT_INT_OSC_KHZ;
            3'h5: int_ticks = `CWT_DLY5_MS * `CWT_INT_OSC_KHZ;
            3'h6: int_ticks = `CWT_DLY6_MS * `CWT_INT_OSC_KHZ;
            3'h7: int_ticks = `CWT_DLY7_MS * `CWT_INT_OSC_KHZ;
            default: int_ticks = {CNT_W{1'b0}};
         endcase
      end
   endfunction

   // external source: delay select to divide ratio
   function [CNT_W-1:0] ext_ticks;
      input [2:0] sel;
      begin
         case (sel)
            3'h1: ext_ticks = `CWT_XDIV1;
            3'h2: ext_ticks = `CWT_XDIV2;
            3'h3: ext_ticks = `CWT_XDIV3;
            3'h4: ext_ticks = `CWT_XDIV4;
            3'h5: ext_ticks = `CWT_XDIV5;
            3'h6: ext_ticks = `CWT_XDIV6;
            3'h7: ext_ticks = `CWT_XDIV7;
            default: ext_ticks = {CNT_W{1'b0}};
         endcase
      end
   endfunction

   function [CNT_W-1:0] period;
      input ext;
      input [2:0] sel;
      begin
         period = ext ? ext_ticks(sel) : int_ticks(sel);
      end
   endfunction

   // ========================================
   // state
   reg co_pin_en_r;
   reg [DIV_W-1:0] co_div_r;
   reg [DIV_W-1:0] co_cnt_r;
   reg co_phase_r;
   reg wk_flag_r;
   reg wk_clksel_r;
   reg wk_ie_r;
   reg [2:0] wk_dly_r;
   reg [CNT_W-1:0] wk_cnt_r;
   reg [`CWT_IRQ_BITS-1:0] irq_status_r;
   reg [`CWT_IRQ_BITS-1:0] irq_mask_r;
   localparam SRC_N = 2;
   wire [SRC_N-1:0] src_pin = {ext_xtal_clk, int_osc_clk};
   wire [SRC_N-1:0] src_tick;
   reg [7:0] aw_addr_r;
   reg aw_full_r;
   reg [31:0] w_data_r;
   reg w_strb0_r;
   reg w_full_r;

   // ========================================
   // combinational decode
   wire aw_hs = s_axi_awvalid & s_axi_awready;
   wire w_hs = s_axi_wvalid & s_axi_wready;
   wire ar_hs = s_axi_arvalid & s_axi_arready;
   wire wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
   wire wr_ok = wr_go & mapped(aw_addr_r) & w_strb0_r;
   wire [7:0] wb = w_data_r[7:0];
   wire wr_co = wr_ok & (aw_addr_r == `CWT_OFS_CLK_OUT_CTRL);
   wire wr_wk = wr_ok & (aw_addr_r == `CWT_OFS_WAKE_STAT_CTRL);
   wire wr_mask = wr_ok & (aw_addr_r == `CWT_OFS_IRQ_MASK);
   wire rd_stat = ar_hs & (s_axi_araddr == `CWT_OFS_IRQ_STATUS);
   wire osc_tick = src_tick[0];
   wire xtal_tick = src_tick[1];
   wire wk_tick = wk_clksel_r ? xtal_tick : osc_tick;
   wire [CNT_W-1:0] wk_period = period(wk_clksel_r, wk_dly_r);
   wire wk_expire = (wk_dly_r != 3'h0) & wk_tick &
                    (wk_cnt_r == wk_period - 1'b1);
   wire wk_ack = wr_wk & wb[`CWT_WK_ACK_BIT];
   wire [`CWT_IRQ_BITS-1:0] irq_set = {wk_expire};
   reg [7:0] rd_byte;
   reg [`CWT_IRQ_BITS-1:0] irq_status_nxt;

   always @* begin
      rd_byte = `CWT_RST_BYTE;
      case (s_axi_araddr)
         `CWT_OFS_CLK_OUT_CTRL: begin
            rd_byte[`CWT_CO_PIN_EN_BIT] = co_pin_en_r;
            rd_byte[`CWT_CO_DIV_MSB:`CWT_CO_DIV_LSB] = co_div_r;
         end
         `CWT_OFS_PART_HIGH: rd_byte[3:0] = PART_ID[11:8];
         `CWT_OFS_PART_LOW: rd_byte = PART_ID[7:0];
         `CWT_OFS_WAKE_STAT_CTRL: begin
            rd_byte[`CWT_WK_FLAG_BIT] = wk_flag_r;
            rd_byte[`CWT_WK_CLKSEL_BIT] = wk_clksel_r;
            rd_byte[`CWT_WK_IE_BIT] = wk_ie_r;
            rd_byte[`CWT_WK_DLY_MSB:`CWT_WK_DLY_LSB] = wk_dly_r;
         end
         `CWT_OFS_IRQ_STATUS: rd_byte[`CWT_IRQ_BITS-1:0] = irq_status_r;
         `CWT_OFS_IRQ_MASK: rd_byte[`CWT_IRQ_BITS-1:0] = irq_mask_r;
         default: rd_byte = `CWT_RST_BYTE;
      endcase
   end

   always @* begin
      irq_status_nxt = irq_status_r;
      if (rd_stat) begin
         irq_status_nxt = {`CWT_IRQ_BITS{1'b0}};
      end
      irq_status_nxt = irq_status_nxt | irq_set;
   end

   // ========================================
   // axi4-lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CWT_RESP_OKAY;
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= `CWT_RST_BYTE;
         w_data_r <= `CWT_RST_WORD;
         w_strb0_r <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_addr_r <= s_axi_awaddr;
            aw_full_r <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_hs) begin
            w_data_r <= s_axi_wdata;
            w_strb0_r <= s_axi_wstrb[0];
            w_full_r <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_r) ? `CWT_RESP_OKAY : `CWT_RESP_SLVERR;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ========================================
   // axi4-lite read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `CWT_RST_WORD;
         s_axi_rresp <= `CWT_RESP_OKAY;
      end else begin
         if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= mapped(s_axi_araddr) ? `CWT_RESP_OKAY : `CWT_RESP_SLVERR;
         end
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ========================================
   // control registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         co_pin_en_r <= 1'b0;
         co_div_r <= {DIV_W{1'b0}};
         wk_clksel_r <= 1'b0;
         wk_ie_r <= 1'b0;
         wk_dly_r <= 3'h0;
         irq_mask_r <= {`CWT_IRQ_BITS{1'b0}};
      end else begin
         if (wr_co) begin
            co_pin_en_r <= wb[`CWT_CO_PIN_EN_BIT];
            co_div_r <= wb[`CWT_CO_DIV_MSB:`CWT_CO_DIV_LSB];
         end
         if (wr_wk) begin
            wk_clksel_r <= wb[`CWT_WK_CLKSEL_BIT];
            wk_ie_r <= wb[`CWT_WK_IE_BIT];
            wk_dly_r <= wb[`CWT_WK_DLY_MSB:`CWT_WK_DLY_LSB];
         end
         if (wr_mask) begin
            irq_mask_r <= wb[`CWT_IRQ_BITS-1:0];
         end
      end
   end

   // ========================================
   // clock output divider
   always @(posedge aclk) begin
      if (!aresetn) begin
         co_cnt_r <= {DIV_W{1'b0}};
         co_phase_r <= 1'b0;
         port_c_bit_two_pin_o <= 1'b0;
         port_c_bit_two_pin_oe <= 1'b0;
      end else begin
         if (co_div_r == {DIV_W{1'b0}} || !co_pin_en_r) begin
            co_cnt_r <= {DIV_W{1'b0}};
            co_phase_r <= 1'b0;
         end else if (co_cnt_r >= co_div_r - 1'b1) begin
            co_cnt_r <= {DIV_W{1'b0}};
            co_phase_r <= ~co_phase_r;
         end else begin
            co_cnt_r <= co_cnt_r + 1'b1;
         end
         port_c_bit_two_pin_oe <= co_pin_en_r;
         port_c_bit_two_pin_o <= co_pin_en_r & co_phase_r;
      end
   end

   // ========================================
   // oscillator and crystal synchronisers
   // one two-flop synchroniser and edge detector per tick source
   genvar gi;
   generate
      for (gi = 0; gi < SRC_N; gi = gi + 1) begin : g_sync
         reg [2:0] sync_r;
         always @(posedge aclk) begin
            if (!aresetn) begin
               sync_r <= 3'h0;
            end else begin
               sync_r <= {sync_r[1:0], src_pin[gi]};
            end
         end
         assign src_tick[gi] = sync_r[1] & ~sync_r[2];
      end
   endgenerate

   // ========================================
   // wakeup timer
   always @(posedge aclk) begin
      if (!aresetn) begin
         wk_cnt_r <= {CNT_W{1'b0}};
         wk_flag_r <= 1'b0;
      end else begin
         if (wk_dly_r == 3'h0 || wr_wk) begin
            wk_cnt_r <= {CNT_W{1'b0}};
         end else if (wk_expire) begin
            wk_cnt_r <= {CNT_W{1'b0}};
         end else if (wk_tick) begin
            wk_cnt_r <= wk_cnt_r + 1'b1;
         end
         if (wk_expire) begin
            wk_flag_r <= 1'b1;
         end else if (wk_ack) begin
            wk_flag_r <= 1'b0;
         end
      end
   end

   // ========================================
   // interrupts
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_r <= {`CWT_IRQ_BITS{1'b0}};
         wakeup_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         irq_status_r <= irq_status_nxt;
         wakeup_irq <= wk_flag_r & wk_ie_r;
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

endmodule

// *** dv/cwt_properties.sv ***
// assertion checker for the clock out and wakeup timer
`include "cwt_defines.vh"
module cwt_properties #(
   parameter [11:0] PART_ID = 12'h5A3 // arbitrary value
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire port_c_bit_two_pin_o,
   input wire port_c_bit_two_pin_oe,
   input wire wakeup_irq,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire ar_go = s_axi_arvalid && s_axi_arready;
   wire aw_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // ========================================
   // properties
   property p_pin_off;
      !port_c_bit_two_pin_oe |-> !port_c_bit_two_pin_o;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin active while disabled");
   property p_part_high;
      ar_go && s_axi_araddr == `CWT_OFS_PART_HIGH |=> s_axi_rdata == {28'h0, PART_ID[11:8]};
   endproperty
   a_part_high: assert property (p_part_high) else $error("bad high part number");
   property p_part_low;
      ar_go && s_axi_araddr == `CWT_OFS_PART_LOW |=> s_axi_rdata == {24'h0, PART_ID[7:0]};
   endproperty
   a_part_low: assert property (p_part_low) else $error("bad low part number");
   property p_wake_zero;
      ar_go && s_axi_araddr == `CWT_OFS_WAKE_STAT_CTRL |=> !s_axi_rdata[6] && !s_axi_rdata[3];
   endproperty
   a_wake_zero: assert property (p_wake_zero) else $error("wakeup zero bits set");
   property p_unmapped;
      ar_go && s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
   property p_rd_lat;
      ar_go |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_wr_lat;
      aw_go |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   cover property (port_c_bit_two_pin_oe && $rose(port_c_bit_two_pin_o));
   cover property ($rose(wakeup_irq));
   cover property ($rose(irq));
endmodule
bind cwt_top cwt_properties #(.PART_ID(PART_ID)) cwt_properties_i (.*);

// *** dv/cwt_pin_load.sv ***
// pin load that measures the half period of the divided clock
module cwt_pin_load (
   input wire aclk,
   input wire pin_o,
   input wire pin_oe,
   output integer half_len
);
   timeunit 1ns;
   timeprecision 1ps;
   integer run_r = 0;
   logic last_r = 0;
   // a released pin rests on its pull-down
   wire line = pin_oe ? pin_o : 1'b0;
   always @(posedge aclk) begin
      if (line !== last_r) begin
         half_len <= run_r;
         run_r <= 1;
      end else run_r <= run_r + 1;
      last_r <= line;
   end
endmodule

// *** dv/tb_clock_out_and_wakeup_timer.sv ***
// self-checking bench for the clock out and wakeup timer
`include "cwt_defines.vh"
module tb_clock_out_and_wakeup_timer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [11:0] PID = 12'h3C9; // arbitrary value
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, int_osc_clk = 0, ext_xtal_clk = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire port_c_bit_two_pin_o, port_c_bit_two_pin_oe, wakeup_irq, irq;
   integer n_mismatch = 0, tests_run = 0, seed = 32'he5358355, half_len, hp, oc = 0, k, c, d;
   cwt_top #(.PART_ID(PID)) cwt_top_i (.*);
   cwt_pin_load cwt_pin_load_i (.aclk(aclk), .pin_o(port_c_bit_two_pin_o),
      .pin_oe(port_c_bit_two_pin_oe), .half_len(half_len));
   always #25 aclk = ~aclk;
   // ========================================
   // both sources run free, 2*hp cycles a period
   always @(posedge aclk) begin
      oc <= (oc == hp - 1) ? 0 : oc + 1;
      if (oc == hp - 1) begin
         int_osc_clk <= ~int_osc_clk;
         ext_xtal_clk <= ~ext_xtal_clk;
      end
   end
   // ========================================
   // checks and bus tasks
   task complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input [63:0] nm, input [31:0] s, input [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0s exp %h seen %h", nm, e, s);
      end
   endtask
   task tmo;
      chk("wait", 0, 1);
      complete_run;
   endtask
   task wr(input [7:0] a, input [7:0] v, input [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 0;
      if (k == 40) tmo;
      chk("bresp", s_axi_bresp, r);
      @(posedge aclk);
   endtask
   task rd(input [7:0] a, input [31:0] e, input [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 0;
      if (k == 40) tmo;
      chk("rdata", s_axi_rdata, e);
      chk("rresp", s_axi_rresp, r);
      @(posedge aclk);
   endtask
   function integer nticks(input x, input [2:0] cd);
      nticks = x ? (cd == 1 ? 256 : 512 << (cd - 1)) : (cd == 1 ? 8 : 16 << (cd - 1));
   endfunction
   task wake(input x, input [2:0] cd);
      integer n;
      n = nticks(x, cd) * 2 * hp;
      wr(`CWT_OFS_WAKE_STAT_CTRL, {2'b01, x, 2'b10, cd}, 0);
      for (k = 0; k < n + 60 && wakeup_irq !== 1; k++) @(posedge aclk);
      if (k == n + 60) tmo;
      chk("period", k >= n - 2 * hp + 1 && k <= n, 1);
      rd(`CWT_OFS_WAKE_STAT_CTRL, {24'h0, 2'b10, x, 2'b10, cd}, 0);
      rd(`CWT_OFS_IRQ_STATUS, 1, 0);
      rd(`CWT_OFS_IRQ_STATUS, 0, 0);
      wr(`CWT_OFS_WAKE_STAT_CTRL, 8'h40, 0);
      repeat (2) @(posedge aclk);
      chk("wirq", wakeup_irq, 0);
   endtask
   // ========================================
   // main sequence
   initial begin
      hp = 2 + $unsigned($random(seed)) % 2;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      rd(`CWT_OFS_CLK_OUT_CTRL, 0, 0);
      rd(`CWT_OFS_WAKE_STAT_CTRL, 0, 0);
      wr(`CWT_OFS_PART_HIGH, $random(seed), 0);
      rd(`CWT_OFS_PART_HIGH, {28'h0, PID[11:8]}, 0);
      rd(`CWT_OFS_PART_LOW, {24'h0, PID[7:0]}, 0);
      wr(8'h18, 8'hFF, 2);
      rd(8'h18, 0, 2);
      for (c = 0; c < 11; c++) begin
         d = c < 7 ? c + 1 : 1 + $unsigned($random(seed)) % 7;
         wr(`CWT_OFS_CLK_OUT_CTRL, 8'h10 | d, 0);
         repeat (4 * d + 4) @(posedge aclk);
         chk("half", half_len, d);
         rd(`CWT_OFS_CLK_OUT_CTRL, 8'h10 | d, 0);
      end
      wr(`CWT_OFS_CLK_OUT_CTRL, 8'h10, 0);
      repeat (3) @(posedge aclk);
      chk("pin", {port_c_bit_two_pin_oe, port_c_bit_two_pin_o}, 2);
      wr(`CWT_OFS_CLK_OUT_CTRL, 8'h03, 0);
      repeat (3) @(posedge aclk);
      chk("oe", port_c_bit_two_pin_oe, 0);
      s_axi_wstrb <= 4'h0;
      wr(`CWT_OFS_CLK_OUT_CTRL, 8'h17, 0);
      s_axi_wstrb <= 4'hF;
      rd(`CWT_OFS_CLK_OUT_CTRL, 8'h03, 0);
      for (c = 1; c < 11; c++) wake(c > 7, c > 7 ? c - 7 : c);
      wr(`CWT_OFS_WAKE_STAT_CTRL, 8'h01, 0);
      repeat (80) @(posedge aclk);
      chk("wirq", wakeup_irq, 0);
      rd(`CWT_OFS_WAKE_STAT_CTRL, 8'h81, 0);
      wr(`CWT_OFS_WAKE_STAT_CTRL, 8'h00, 0);
      rd(`CWT_OFS_WAKE_STAT_CTRL, 8'h80, 0);
      wr(`CWT_OFS_WAKE_STAT_CTRL, 8'h40, 0);
      chk("irq", irq, 0);
      wr(`CWT_OFS_IRQ_MASK, 1, 0);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 1);
      rd(`CWT_OFS_IRQ_STATUS, 1, 0);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 0);
      repeat (200) @(posedge aclk);
      rd(`CWT_OFS_WAKE_STAT_CTRL, 0, 0);
      complete_run;
   end
endmodule
